// [src/ddrw_top.sv]
// apb registers, clock crossing and link-side write timing logic
`timescale 1ns/1ps
module ddrw_top
    import ddrw_pkg::*;
(
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // command link, on the link clock
    input  wire logic        clk_link,
    input  wire logic        cmdValid,
    input  wire logic [2:0]  cmdCode,
    input  wire logic [1:0]  cmdGroup,
    input  wire logic [1:0]  cmdBank,
    input  wire logic        cmdA12,
    // link-side results
    output logic             dataWindow,
    output logic             burstChop,
    output logic             apFire,
    output logic      [3:0]  apBank,
    output logic             timingFault
);
    // ---------------- system domain ----------------
    logic [31:0]          modeQ;
    logic [31:0]          twrQ;
    logic [31:0]          wtrQ;
    logic [31:0]          wtxQ;
    logic [NUM_VIOL-1:0]  violQ;
    logic [NUM_VIOL-1:0]  violSet;
    logic [NUM_VIOL-1:0]  violClr;
    logic                 cfgTogQ;
    logic                 ackS1Q;
    logic                 ackS2Q;
    logic                 cfgPend;
    logic [NUM_LINKV-1:0] evS1Q;
    logic [NUM_LINKV-1:0] evS2Q;
    logic [NUM_LINKV-1:0] evS3Q;
    logic [NUM_LINKV-1:0] vTogQ;
    logic                 cfgAckQ;
    logic                 apbSetup;
    logic                 apbWr;
    logic                 addrOk;
    logic                 cwlBad;
    logic [31:0]          rdMux;

    assign apbSetup = psel && !penable;
    assign apbWr    = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addrOk;
    assign cfgPend  = cfgTogQ != ackS2Q;

    always_comb begin
        addrOk = 1'b1;
        rdMux  = 32'h00000000;
        if (paddr == OFF_MODE) begin
            rdMux = modeQ;
        end else if (paddr == OFF_TWR) begin
            rdMux = twrQ;
        end else if (paddr == OFF_TWTR) begin
            rdMux = wtrQ;
        end else if (paddr == OFF_TWTX) begin
            rdMux = wtxQ;
        end else if (paddr == OFF_STAT) begin
            rdMux[NUM_VIOL-1:0] = violQ;
            rdMux[F_PEND]       = cfgPend;
        end else begin
            addrOk = 1'b0;
        end
    end

    // read data is latched in the setup cycle so it leaves a flop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (apbSetup) begin
            prdata <= rdMux;
        end
    end

    // configuration words; a write to mode, twr, twtr or twtx re-arms the crossing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeQ   <= MODE_RST;
            twrQ    <= TWR_RST;
            wtrQ    <= TWTR_RST;
            wtxQ    <= TWTX_RST;
            cfgTogQ <= 1'b0;
        end else if (apbWr) begin
            if (paddr == OFF_MODE) begin
                modeQ   <= pwdata & MODE_MASK;
                cfgTogQ <= !cfgTogQ;
            end else if (paddr == OFF_TWR) begin
                twrQ    <= pwdata & TIME_MASK;
                cfgTogQ <= !cfgTogQ;
            end else if (paddr == OFF_TWTR) begin
                wtrQ    <= pwdata & TIME_MASK;
                cfgTogQ <= !cfgTogQ;
            end else if (paddr == OFF_TWTX) begin
                wtxQ    <= pwdata & TIME_MASK;
                cfgTogQ <= !cfgTogQ;
            end
        end
    end

    assign cwlBad = modeQ[F_PRE2] && (modeQ[F_CWL +: CW_W] <= CWL_LOWEST); // RULE6

    always_comb begin
        violClr = '0;
        if (apbWr && paddr == OFF_STAT) begin
            violClr = pwdata[NUM_VIOL-1:0];
        end
        violSet = {cwlBad, evS2Q ^ evS3Q};
    end

    // sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            violQ <= '0;
        end else begin
            violQ <= (violQ & ~violClr) | violSet;
        end
    end

    // link event toggles pass three flops (the last for edge detect), config acknowledge two
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            evS1Q  <= '0;
            evS2Q  <= '0;
            evS3Q  <= '0;
            ackS1Q <= 1'b0;
            ackS2Q <= 1'b0;
        end else begin
            evS1Q  <= vTogQ;
            evS2Q  <= evS1Q;
            evS3Q  <= evS2Q;
            ackS1Q <= cfgAckQ;
            ackS2Q <= ackS1Q;
        end
    end

    // ---------------- link domain ----------------
    logic                 lRstS1Q;
    logic                 linkRst_n;
    logic                 cfgS1Q;
    logic                 cfgS2Q;
    logic [31:0]          lModeQ;
    logic [31:0]          lTwrQ;
    logic [31:0]          lWtrQ;
    logic [31:0]          lWtxQ;
    logic [NUM_LINKV-1:0] vLink;

    always_ff @(posedge clk_link) begin
        lRstS1Q   <= rst_n;
        linkRst_n <= lRstS1Q;
    end

    // the link copies the words once the toggle has crossed; apb writes are not held off while the acknowledge is pending
    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            cfgS1Q  <= 1'b0;
            cfgS2Q  <= 1'b0;
            cfgAckQ <= 1'b0;
            lModeQ  <= MODE_RST;
            lTwrQ   <= TWR_RST;
            lWtrQ   <= TWTR_RST;
            lWtxQ   <= TWTX_RST;
        end else begin
            cfgS1Q  <= cfgTogQ;
            cfgS2Q  <= cfgS1Q;
            cfgAckQ <= cfgS2Q;
            if (cfgS2Q != cfgAckQ) begin
                lModeQ <= modeQ;
                lTwrQ  <= twrQ;
                lWtrQ  <= wtrQ;
                lWtxQ  <= wtxQ;
            end
        end
    end

    ddrw_burst_if bif ();

    ddrw_burst u_burst (
        .bus (bif.dec)
    );

    logic             isWr;
    logic             isWra;
    logic             isRd;
    logic             isPre;
    logic             isPrea;
    logic [3:0]       bankIdx;
    logic [CNT_W-1:0] cwl8;
    logic [CNT_W-1:0] half8;
    logic [CNT_W-1:0] twrEff;
    logic [CNT_W-1:0] wtrSEff;
    logic [CNT_W-1:0] wtrLEff;
    logic [CNT_W-1:0] wrBase;
    logic [CNT_W-1:0] prLoad;
    logic [CNT_W-1:0] wtrSLoad;
    logic [CNT_W-1:0] wtrLLoad;
    logic [CNT_W-1:0] rdSum;
    logic [CNT_W-1:0] rtwLoad;
    logic             dbiOnly;
    logic             crcDm;

    assign isWra   = cmdValid && cmdCode == CMD_WRA;
    assign isWr    = (cmdValid && cmdCode == CMD_WR) || isWra;
    assign isRd    = cmdValid && (cmdCode == CMD_RD || cmdCode == CMD_RDA);
    assign isPre   = cmdValid && cmdCode == CMD_PRE;
    assign isPrea  = cmdValid && cmdCode == CMD_PREA;
    assign bankIdx = {cmdGroup, cmdBank};

    assign bif.mode    = lModeQ[F_BURST +: 2];
    assign bif.a12     = cmdA12;
    assign bif.isWrite = isWr;

    assign cwl8    = {3'h0, lModeQ[F_CWL +: CW_W]};
    assign half8   = {4'h0, bif.halfLen};
    assign dbiOnly = lModeQ[F_DBI] && !lModeQ[F_CRC];
    assign crcDm   = lModeQ[F_CRC] && lModeQ[F_DM];

    always_comb begin
        twrEff  = {1'b0, lTwrQ[F_LO +: FW]};
        wtrSEff = {1'b0, lWtrQ[F_LO +: FW]};
        wtrLEff = {1'b0, lWtrQ[F_MID +: FW]};
        if (crcDm) begin
            twrEff  = {1'b0, lTwrQ[F_HI +: FW]}; // RULE14
            wtrSEff = {1'b0, lWtxQ[F_LO +: FW]};
            wtrLEff = {1'b0, lWtxQ[F_MID +: FW]};
        end else if (dbiOnly) begin
            twrEff  = {1'b0, lTwrQ[F_MID +: FW]}; // RULE13
            wtrSEff = wtrSEff + {1'b0, lWtxQ[F_HI +: FW]};
            wtrLEff = wtrLEff + {1'b0, lWtxQ[F_HI +: FW]};
        end
    end

    // counters load one less than the interval: zero means allowed
    function automatic logic [CNT_W-1:0] minusOne(input logic [CNT_W-1:0] x);
        minusOne = (x == '0) ? '0 : x - PRE_ONE;
    endfunction

    always_comb begin
        wrBase   = cwl8 + half8;
        prLoad   = minusOne(wrBase + twrEff); // RULE1
        wtrSLoad = minusOne(wrBase + wtrSEff); // RULE10
        wtrLLoad = minusOne(wrBase + wtrLEff); // RULE9
        rdSum    = {3'h0, lModeQ[F_CL +: CW_W]} + half8 + RTW_PAD
                 + (lModeQ[F_PRE2] ? PRE_TWO : PRE_ONE);
        // a read sum (cl, half burst, pad, preamble) not above cwl leaves no gap to enforce
        rtwLoad  = (rdSum > cwl8) ? minusOne(rdSum - cwl8) : '0; // RULE8
    end

    logic [CNT_W-1:0]    prWaitQ [NUM_BANK];
    logic [CNT_W-1:0]    apWaitQ [NUM_BANK];
    logic [CNT_W-1:0]    wtrLQ [NUM_GRP];
    logic [NUM_BANK-1:0] apHit;
    logic [NUM_BANK-1:0] apPendQ;
    logic [NUM_BANK-1:0] apGrant;
    logic [NUM_BANK-1:0] prBusy;

    for (genvar i = 0; i < NUM_BANK; i++) begin : g_bank
        always_ff @(posedge clk_link) begin
            if (!linkRst_n) begin
                prWaitQ[i] <= '0;
                apWaitQ[i] <= '0;
            end else begin
                if (isWr && bankIdx == 4'(i)) begin
                    prWaitQ[i] <= prLoad; // RULE16
                end else if (prWaitQ[i] != '0) begin
                    prWaitQ[i] <= prWaitQ[i] - PRE_ONE;
                end
                if (isWra && bankIdx == 4'(i)) begin
                    apWaitQ[i] <= prLoad; // RULE2
                end else if (apWaitQ[i] != '0) begin
                    apWaitQ[i] <= apWaitQ[i] - PRE_ONE;
                end
            end
        end
        assign apHit[i]  = apWaitQ[i] == PRE_ONE;
        assign prBusy[i] = prWaitQ[i] != '0;
    end

    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        always_ff @(posedge clk_link) begin
            if (!linkRst_n) begin
                wtrLQ[g] <= '0;
            end else if (isWr && cmdGroup == 2'(g)) begin
                wtrLQ[g] <= wtrLLoad; // RULE9
            end else if (wtrLQ[g] != '0) begin
                wtrLQ[g] <= wtrLQ[g] - PRE_ONE;
            end
        end
    end

    // one internal precharge per cycle, lowest bank first
    always_comb begin
        apGrant = '0;
        for (int k = NUM_BANK - 1; k >= 0; k--) begin
            if (apPendQ[k]) begin
                apGrant = '0;
                apGrant[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            apPendQ <= '0;
            apFire  <= 1'b0;
            apBank  <= 4'h0;
        end else begin
            apPendQ <= (apPendQ & ~apGrant) | apHit; // RULE2
            apFire  <= apPendQ != '0;
            for (int k = 0; k < NUM_BANK; k++) begin
                if (apGrant[k]) begin
                    apBank <= 4'(k);
                end
            end
        end
    end

    logic [CNT_W-1:0] wtrSQ;
    logic [CNT_W-1:0] rtwQ;
    logic [CNT_W-1:0] ccdQ;
    logic [1:0]       lastGrpQ;

    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            wtrSQ    <= '0;
            lastGrpQ <= 2'h0;
            ccdQ     <= '0;
        end else if (isWr) begin
            wtrSQ    <= wtrSLoad; // RULE10
            lastGrpQ <= cmdGroup;
            ccdQ     <= PRE_ONE;
        end else begin
            if (wtrSQ != '0) begin
                wtrSQ <= wtrSQ - PRE_ONE;
            end
            // saturate; zero means no write seen yet
            if (ccdQ != '0 && ccdQ != '1) begin
                ccdQ <= ccdQ + PRE_ONE;
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            rtwQ <= '0;
        end else if (isRd) begin
            rtwQ <= rtwLoad; // RULE8
        end else if (rtwQ != '0) begin
            rtwQ <= rtwQ - PRE_ONE;
        end
    end

    always_comb begin
        vLink = '0;
        if ((isPre && prWaitQ[bankIdx] != '0) || (isPrea && prBusy != '0)) begin
            vLink[V_PRE] = 1'b1; // RULE1
        end
        if (isWr && rtwQ != '0) begin
            vLink[V_RTW] = 1'b1; // RULE8
        end
        if (isRd && wtrLQ[cmdGroup] != '0) begin
            vLink[V_WTRL] = 1'b1; // RULE9
        end
        if (isRd && cmdGroup != lastGrpQ && wtrSQ != '0) begin
            vLink[V_WTRS] = 1'b1; // RULE10
        end
        if (isWr && lModeQ[F_CRC] && lModeQ[F_PRE2] && ccdQ == CCD_BANNED) begin
            vLink[V_CCD] = 1'b1; // RULE7
        end
    end

    // two faults of one kind within one system clock can cancel their toggles and set no flag
    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            vTogQ       <= '0;
            timingFault <= 1'b0;
        end else begin
            vTogQ       <= vTogQ ^ vLink;
            timingFault <= vLink != '0;
        end
    end

    // data window: bit k reaches the output k+1 cycles after the write
    logic [WIN_W-1:0] winQ;
    logic [WIN_W-1:0] winMask;

    always_comb begin
        winMask = '0;
        for (int k = 0; k < WIN_W; k++) begin
            if (isWr && (k + 1) >= int'(cwl8) && (k + 1) < int'(wrBase)) begin
                winMask[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (!linkRst_n) begin
            winQ       <= '0;
            dataWindow <= 1'b0;
            burstChop  <= 1'b0;
        end else begin
            winQ       <= {1'b0, winQ[WIN_W-1:1]} | winMask;
            dataWindow <= winQ[0];
            if (isWr) begin
                burstChop <= bif.chop; // RULE4
            end
        end
    end
endmodule

// [include/ddrw_pkg.sv]
// package: offsets, fields, reset values and codes of the write timing block
// How it works
// RULE1: precharge to a bank waits write recovery after that bank's last data edge.
// RULE2: auto precharge happens only after write recovery following the last data beat.
// RULE3: burst mode 1:0 makes every write a fixed chop of four, a12 ignored.
// RULE4: burst mode 0:1 samples a12 per write: low chops four, high bursts eight.
// RULE5: burst mode 0:0 makes every write a fixed burst of eight.
// RULE6: two-clock preamble needs write latency above the lowest, so nine is illegal.
// RULE7: with crc and two-clock preamble, write to write spacing of six is banned.
// RULE8: read to write waits cl minus cwl, half burst, one clock, preamble.
// RULE9: write to read in the same group waits cwl, half burst, long wtr.
// RULE10: write to read in another group waits cwl, half burst, short wtr.
// RULE11: read burst counts eight for fixed or otf eight, four for any chop.
// RULE12: write burst counts eight except in fixed chop mode, which counts four.
// RULE13: dbi without crc uses the dbi recovery and write to read values.
// RULE14: crc together with data mask uses the crc-mask recovery and wtr values.
// RULE15: these intervals hold only with extended zq calibration times observed.
// RULE16: controller tracks bank and group completions, blocking commands until intervals expire; this block only flags violations, it blocks nothing.
package ddrw_pkg;
    localparam int CNT_W     = 8;
    localparam int FW        = 7;
    localparam int CW_W      = 5;
    localparam int NUM_BANK  = 16;
    localparam int NUM_GRP   = 4;
    localparam int WIN_W     = 32;
    localparam int NUM_LINKV = 5;
    localparam int NUM_VIOL  = 6;

    // apb byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_TWR  = 8'h04;
    localparam logic [7:0] OFF_TWTR = 8'h08;
    localparam logic [7:0] OFF_TWTX = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;

    // mode word fields
    localparam int F_BURST = 0;
    localparam int F_PRE2  = 2;
    localparam int F_DBI   = 3;
    localparam int F_CRC   = 4;
    localparam int F_DM    = 5;
    localparam int F_CWL   = 8;
    localparam int F_CL    = 16;
    // timing word fields, seven bits each
    localparam int F_LO    = 0;
    localparam int F_MID   = 8;
    localparam int F_HI    = 16;
    // status word fields
    localparam int F_PEND  = 8;

    localparam logic [31:0] MODE_RST  = 32'h000B0900;
    localparam logic [31:0] TWR_RST   = 32'h000E0D0C;
    localparam logic [31:0] TWTR_RST  = 32'h00000602;
    localparam logic [31:0] TWTX_RST  = 32'h00010703;
    localparam logic [31:0] MODE_MASK = 32'h001F1F3F;
    localparam logic [31:0] TIME_MASK = 32'h007F7F7F;

    // burst mode field values
    localparam logic [1:0] BM_BL8 = 2'h0;
    localparam logic [1:0] BM_OTF = 2'h1;
    localparam logic [1:0] BM_BC4 = 2'h2;

    // command codes on the link
    localparam logic [2:0] CMD_WR   = 3'h1;
    localparam logic [2:0] CMD_WRA  = 3'h2;
    localparam logic [2:0] CMD_RD   = 3'h3;
    localparam logic [2:0] CMD_RDA  = 3'h4;
    localparam logic [2:0] CMD_PRE  = 3'h5;
    localparam logic [2:0] CMD_PREA = 3'h6;

    // violation bits in the status word
    localparam int V_PRE  = 0;
    localparam int V_RTW  = 1;
    localparam int V_WTRL = 2;
    localparam int V_WTRS = 3;
    localparam int V_CCD  = 4;
    localparam int V_CWL  = 5;

    localparam logic [CW_W-1:0]  CWL_LOWEST = 5'h09;
    localparam logic [CNT_W-1:0] CCD_BANNED = 8'h06;
    localparam logic [CNT_W-1:0] RTW_PAD    = 8'h01;
    localparam logic [CNT_W-1:0] PRE_ONE    = 8'h01;
    localparam logic [CNT_W-1:0] PRE_TWO    = 8'h02;
    localparam logic [3:0]       HALF_BL8   = 4'h4;
    localparam logic [3:0]       HALF_BC4   = 4'h2;
endpackage

// [include/ddrw_burst_if.sv]
// carrier between the command logic and the burst length decoder
`timescale 1ns/1ps
interface ddrw_burst_if;
    logic [1:0] mode;
    logic       a12;
    logic       isWrite;
    logic       chop;
    logic [3:0] halfLen;

    modport core (output mode, output a12, output isWrite, input chop, input halfLen);
    modport dec (input mode, input a12, input isWrite, output chop, output halfLen);
endinterface

// [src/ddrw_burst.sv]
// burst length decoder: chop flag and half burst length of one command
`timescale 1ns/1ps
module ddrw_burst
    import ddrw_pkg::*;
(
    // decode side of the burst carrier
    ddrw_burst_if.dec bus
);
    logic otfChop;

    assign otfChop = (bus.mode == BM_OTF) && !bus.a12; // RULE4

    always_comb begin
        // fixed eight, and the reserved code, fall to the default
        bus.chop    = 1'b0;
        bus.halfLen = HALF_BL8; // RULE5
        if (bus.mode == BM_BC4) begin
            bus.chop    = 1'b1; // RULE3
            bus.halfLen = HALF_BC4; // RULE12
        end else if (otfChop) begin
            bus.chop = 1'b1;
            // an otf chop still books eight for writes, four for reads
            if (bus.isWrite) begin
                bus.halfLen = HALF_BL8; // RULE12
            end else begin
                bus.halfLen = HALF_BC4; // RULE11
            end
        end
    end
endmodule

// [verif/ddrw_properties.sv]
// checker: port properties of the write timing block
`timescale 1ns/1ps
module ddrw_properties
    import ddrw_pkg::*;
(
    // system side
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // link side
    input wire logic        clk_link,
    input wire logic        cmdValid,
    input wire logic [2:0]  cmdCode,
    input wire logic        cmdA12,
    input wire logic        dataWindow,
    input wire logic        burstChop,
    input wire logic        timingFault
);
    logic [1:0] mode_q;
    logic       acc;
    logic       isWr;
    logic       expChop;
    assign acc = psel && penable;
    assign isWr = cmdValid && (cmdCode == CMD_WR || cmdCode == CMD_WRA);
    // valid once the config has crossed
    assign expChop = mode_q == BM_BC4 || (mode_q == BM_OTF && !cmdA12);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_q <= BM_BL8;
        end else if (acc && pwrite && paddr == OFF_MODE) begin
            mode_q <= pwdata[1:0];
        end
    end
    a_ready_always: assert property (@(posedge clk_sys) disable iff (!rst_n) pready)
        else $error("pready low");
    a_unmapped_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc && paddr > OFF_STAT |-> pslverr && prdata == 32'h0) else $error("unmapped access");
    a_mapped_noerr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        acc && paddr <= OFF_STAT && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped error");
    a_idle_noerr: assert property (@(posedge clk_sys) disable iff (!rst_n) !acc |-> !pslverr)
        else $error("error outside access");
    a_chop_decode: assert property (@(posedge clk_link) disable iff (!rst_n)
        isWr |=> burstChop == $past(expChop)) else $error("chop flag wrong");
    a_chop_hold: assert property (@(posedge clk_link) disable iff (!rst_n)
        !isWr |=> $stable(burstChop)) else $error("chop flag moved");
    a_window_long: assert property (@(posedge clk_link) disable iff (!rst_n)
        $rose(dataWindow) && mode_q != BM_BC4 |-> dataWindow [*4]) else $error("short window");
    a_fault_cause: assert property (@(posedge clk_link) disable iff (!rst_n)
        timingFault |-> $past(cmdValid)) else $error("fault without command");
    a_fault_pulse: assert property (@(posedge clk_link) disable iff (!rst_n)
        timingFault && !cmdValid |=> !timingFault) else $error("fault too long");
endmodule

bind ddrw_top ddrw_properties u_props (.*);

// [verif/ddrw_ctrl_model.sv]
// controller model: issues single commands on the link
`timescale 1ns/1ps
module ddrw_ctrl_model
    import ddrw_pkg::*;
(
    // link clock
    input  wire logic       clk_link,
    // command outputs
    output logic            cmdValid,
    output logic      [2:0] cmdCode,
    output logic      [1:0] cmdGroup,
    output logic      [1:0] cmdBank,
    output logic            cmdA12
);
    // calibration counts as done; the caller sets spacing, legal or not
    initial {cmdValid, cmdCode, cmdGroup, cmdBank, cmdA12} = 9'h000;
    task automatic send(input logic [2:0] c, logic [1:0] g, logic [1:0] b,
                        logic a);
        @(posedge clk_link);
        cmdValid <= 1'b1;
        {cmdCode, cmdGroup, cmdBank, cmdA12} <= {c, g, b, a};
        @(posedge clk_link);
        cmdValid <= 1'b0;
        // released fields flip: no stale command looks live
        {cmdCode, cmdGroup, cmdBank, cmdA12} <= ~{c, g, b, a};
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_link);
    endtask
endmodule

// [verif/ddr4_write_command_timing_tb.sv]
// bench: apb register checks and link timing scenarios
`timescale 1ns/1ps
module ddr4_write_command_timing_tb
    import ddrw_pkg::*;
;
    localparam logic [1:0] G0 = 2'h0;
    localparam logic [1:0] G1 = 2'h1;
    logic        clk_sys = 1'b0;
    logic        clk_link = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmdValid;
    logic [2:0]  cmdCode;
    logic [1:0]  cmdGroup;
    logic [1:0]  cmdBank;
    logic        cmdA12;
    logic        dataWindow;
    logic        burstChop;
    logic        apFire;
    logic [3:0]  apBank;
    logic        timingFault;
    logic [31:0] rd;
    logic        er;
    logic        a = 1'b1;
    int          n_errors = 0;
    int          n_tests = 0;
    int          n;
    logic [7:0]  ra [5] = '{OFF_MODE, OFF_TWR, OFF_TWTR, OFF_TWTX, OFF_STAT};
    logic [31:0] rv [5] = '{MODE_RST, TWR_RST, TWTR_RST, TWTX_RST, 32'h0};
    logic [2:0]  bt [5] = '{3'b101, 3'b010, 3'b011, 3'b000, 3'b110};
    logic        bc [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    always #12.5 clk_sys = ~clk_sys;
    always #6 clk_link = ~clk_link;

    ddrw_top u_dut (.*);
    ddrw_ctrl_model u_ctl (.*);

    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] ad, logic w, logic [31:0] d);
        int i;
        @(posedge clk_sys);
        {psel, penable, paddr, pwrite, pwdata} <= {1'b1, 1'b0, ad, w, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic cfg(input logic [31:0] d);
        int i;
        apb(OFF_MODE, 1'b1, d);
        i = 0;
        do begin
            apb(OFF_STAT, 1'b0, 32'h0);
            i++;
        end while (rd[F_PEND] !== 1'b0 && i < 20);
        chk({31'h0, rd[F_PEND]}, 32'h0);
    endtask
    // second command k link cycles after the first, e the expected fault
    task automatic g(input logic [2:0] c1, logic [1:0] g1, logic [2:0] c2, logic [1:0] g2,
                     int k, logic e);
        u_ctl.idle(40);
        u_ctl.send(c1, g1, 2'h0, a);
        u_ctl.idle(k - 2);
        u_ctl.send(c2, g2, 2'h0, a);
        #1 chk({31'h0, timingFault}, {31'h0, e});
    endtask
    task automatic until_high(input int which);
        while ((which == 0 ? dataWindow : apFire) !== 1'b1 && n < 60) begin
            @(posedge clk_link);
            #1 n++;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(ra[i], 1'b0, 32'h0);
            chk(rd, rv[i]);
        end
        apb(8'h14, 1'b0, 32'h0);
        chk({31'h0, er}, 32'h1);
        cfg(32'hFFFFFFFF);
        apb(OFF_MODE, 1'b0, 32'h0);
        chk(rd, MODE_MASK);
        for (int i = 0; i < 5; i++) begin
            cfg({MODE_RST[31:2], bt[i][2:1]});
            u_ctl.idle(40);
            u_ctl.send(CMD_WR, G0, 2'h0, bt[i][0]);
            @(posedge clk_link);
            #1 n = 1;
            chk({31'h0, burstChop}, {31'h0, bc[i]});
            until_high(0);
            chk(n, 9);
            n = 0;
            while (dataWindow === 1'b1 && n < 20) begin
                @(posedge clk_link);
                #1 n++;
            end
            chk(n, bt[i][2:1] == BM_BC4 ? 2 : 4);
        end
        cfg(MODE_RST);
        g(CMD_WR, G0, CMD_PRE, G0, 24, 1'b1);
        repeat (3) @(posedge clk_sys);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[V_PRE]}, 32'h1);
        apb(OFF_STAT, 1'b1, 32'h1);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[V_PRE]}, 32'h0);
        g(CMD_WR, G0, CMD_PRE, G0, 25, 1'b0);
        g(CMD_WR, G0, CMD_RD, G0, 18, 1'b1);
        g(CMD_WR, G0, CMD_RDA, G0, 19, 1'b0);
        g(CMD_WR, G0, CMD_RD, G1, 14, 1'b1);
        g(CMD_WR, G0, CMD_RD, G1, 15, 1'b0);
        g(CMD_RD, G0, CMD_WR, G1, 7, 1'b1);
        g(CMD_RD, G0, CMD_WR, G0, 8, 1'b0);
        u_ctl.idle(40);
        u_ctl.send(CMD_WRA, 2'h2, 2'h1, 1'b1);
        n = 0;
        until_high(1);
        chk(n, 25);
        chk({28'h0, apBank}, 32'h9);
        cfg(32'h000B0902);
        g(CMD_WR, G0, CMD_RD, G1, 12, 1'b1);
        g(CMD_WR, G0, CMD_RD, G1, 13, 1'b0);
        g(CMD_RD, G0, CMD_WR, G1, 5, 1'b1);
        g(CMD_RD, G0, CMD_WR, G1, 6, 1'b0);
        cfg(32'h000B0901);
        a = 1'b0;
        g(CMD_WR, G0, CMD_RD, G1, 14, 1'b1);
        g(CMD_RD, G0, CMD_WR, G1, 6, 1'b0);
        a = 1'b1;
        cfg(32'h000B0908);
        g(CMD_WR, G0, CMD_PREA, G1, 25, 1'b1);
        g(CMD_WR, G0, CMD_PRE, G0, 26, 1'b0);
        g(CMD_WR, G0, CMD_RD, G1, 15, 1'b1);
        cfg(32'h000B0930);
        g(CMD_WR, G0, CMD_PRE, G0, 26, 1'b1);
        g(CMD_WR, G0, CMD_PRE, G0, 27, 1'b0);
        g(CMD_WR, G0, CMD_RD, G1, 15, 1'b1);
        cfg(32'h000B0A14);
        g(CMD_WR, G0, CMD_WR, G1, 6, 1'b1);
        g(CMD_WR, G0, CMD_WR, G1, 5, 1'b0);
        g(CMD_WR, G0, CMD_WR, G1, 7, 1'b0);
        cfg(32'h000B0904);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[V_CWL]}, 32'h1);
        cfg(MODE_RST);
        apb(OFF_STAT, 1'b1, 32'h3F);
        apb(OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[V_CWL]}, 32'h0);
        tally_and_finish();
    end
endmodule
